// ===== src/osw_pkg.sv
// Shared constants of the octal switch fault status block.
package osw_pkg;
  localparam int          CHANNELS           = 8;
  localparam int          CLK_HZ             = 25_000_000;
  localparam int          FAULT_DELAY_NS     = 25000;
  localparam int          FAULT_DELAY_CYCLES = (FAULT_DELAY_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int          TIMER_W            = 10;
  localparam int          SYNC_W             = 2 * CHANNELS + 4;
  localparam logic [19:0] SYNC_RESET         = 20'h4_0000;
  localparam logic [7:0]  CMD_ALL_OFF        = 8'hFF;
  localparam logic [7:0]  STATUS_ALL_OFF     = 8'hFF;
  localparam logic [7:0]  SHIFT_RESET        = 8'h00;
  localparam logic [7:0]  DRIVE_RESET        = 8'h00;
endpackage

// ===== src/osw_sync.sv
// Three-stage input synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ns
`default_nettype none
module osw_sync #(
  parameter int               WIDTH     = 8,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             reset_n,
  // Raw and filtered levels
  input  wire logic [WIDTH-1:0] rawIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1_q;
  logic [WIDTH-1:0] stage2_q;
  logic [WIDTH-1:0] stage3_q;
  logic [WIDTH-1:0] out_d;

  always_comb
  begin
    out_d = syncOut;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (stage2_q[i] == stage3_q[i])
      begin
        out_d[i] = stage3_q[i];
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stage1_q <= RESET_VAL;
      stage2_q <= RESET_VAL;
      stage3_q <= RESET_VAL;
      syncOut  <= RESET_VAL;
    end
    else
    begin
      stage1_q <= rawIn;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
      syncOut  <= out_d;
    end
  end
endmodule // osw_sync
`default_nettype wire

// ===== src/osw_fault_top.sv
// Serial command and fault status logic of the eight-channel low-side switch.
`timescale 1ns/1ns
`default_nettype none
module osw_fault_top
  import osw_pkg::*;
(
  // Clock and reset
  input  wire logic                          clock,
  input  wire logic                          reset_n,
  // Serial interface pins
  input  wire logic                          sclkPin,
  input  wire logic                          selectLowPin,
  input  wire logic                          siPin,
  output logic                               soOut,
  output logic                               soOutEn,
  // Detector flags from the analog side
  input  wire logic [osw_pkg::CHANNELS-1:0]  overTempPin,
  input  wire logic                          loadSupplyOverPin,
  input  wire logic [osw_pkg::CHANNELS-1:0]  drainCompareThresholdPin,
  // Gate drive, high switches the output on
  output logic      [osw_pkg::CHANNELS-1:0]  switchOn
);
  logic [SYNC_W-1:0]   syncVec;
  logic                sclk;
  logic                selectLow;
  logic                si;
  logic                loadSupplyOver;
  logic [CHANNELS-1:0] overTemp;
  logic [CHANNELS-1:0] drainAbove;

  // The detectors are asynchronous to this clock, so all of them pass the filter.
  osw_sync #(
    .WIDTH     (SYNC_W),
    .RESET_VAL (SYNC_RESET)
  ) u_sync (
    .clock   (clock),
    .reset_n (reset_n),
    .rawIn   ({sclkPin, selectLowPin, siPin, loadSupplyOverPin, overTempPin, drainCompareThresholdPin}),
    .syncOut (syncVec)
  );

  assign {sclk, selectLow, si, loadSupplyOver, overTemp, drainAbove} = syncVec;

  logic                sclkPrev_q;
  logic                selPrev_q;
  logic [CHANNELS-1:0] shift_q;
  logic [CHANNELS-1:0] shift_d;
  logic [CHANNELS-1:0] cmd_q;
  logic [CHANNELS-1:0] cmd_d;
  logic [CHANNELS-1:0] otLatch_q;
  logic [CHANNELS-1:0] otLatch_d;
  logic                ovpLatch_q;
  logic                ovpLatch_d;
  logic [TIMER_W-1:0]  timer_q;
  logic [TIMER_W-1:0]  timer_d;
  logic                timerDone_q;
  logic                timerDone_d;
  logic                so_d;
  logic                soEn_d;
  logic [CHANNELS-1:0] drive_d;
  logic                sclkRise;
  logic                selFall;
  logic                selRise;
  logic                ovpActive;
  logic [CHANNELS-1:0] openLoad;
  logic [CHANNELS-1:0] shortLoad;
  logic [CHANNELS-1:0] statusWord;

  assign sclkRise  = sclk && !sclkPrev_q;
  assign selFall   = !selectLow && selPrev_q;
  assign selRise   = selectLow && !selPrev_q;
  assign ovpActive = ovpLatch_q || loadSupplyOver;

  // One comparator per output reads as open when off and short when on, after the mask.
  // Open load is judged by the command, so a hot output that was commanded on still reads as off.
  assign openLoad  = cmd_q & ~drainAbove & {CHANNELS{timerDone_q}};
  assign shortLoad = switchOn & drainAbove & {CHANNELS{timerDone_q}};

  always_comb
  begin
    statusWord = (~switchOn & ~openLoad) | shortLoad;
    if (ovpActive)
    begin
      statusWord = STATUS_ALL_OFF;
    end
  end

  // Serial shift path and command latch.
  always_comb
  begin
    shift_d = shift_q;
    cmd_d   = cmd_q;
    so_d    = soOut;
    soEn_d  = !selectLow;
    if (selFall)
    begin
      shift_d = statusWord;
      so_d    = statusWord[CHANNELS-1];
    end
    else if (sclkRise && !selectLow)
    begin
      // Bit seven leaves first; the incoming bit enters at the bottom.
      so_d    = shift_q[CHANNELS-1];
      shift_d = {shift_q[CHANNELS-2:0], si};
    end
    if (selRise)
    begin
      cmd_d = shift_q;
    end
  end

  // Fault latches, delay timer and gate drive.
  always_comb
  begin
    otLatch_d   = otLatch_q | overTemp;
    ovpLatch_d  = ovpLatch_q || loadSupplyOver;
    timer_d     = timer_q;
    timerDone_d = timerDone_q;
    if (timer_q != '0)
    begin
      timer_d = timer_q - 1'b1;
      if (timer_q == TIMER_W'(1))
      begin
        timerDone_d = 1'b1;
      end
    end
    if (selRise)
    begin
      // A new write releases cooled outputs and a cleared overvoltage; a live fault still sets.
      otLatch_d   = overTemp;
      ovpLatch_d  = loadSupplyOver;
      timer_d     = TIMER_W'(FAULT_DELAY_CYCLES);
      timerDone_d = 1'b0;
    end
    // The drive follows the latched command, not the live shift register.
    drive_d = ~cmd_q & ~otLatch_q & ~overTemp;
    if (ovpActive)
    begin
      drive_d = DRIVE_RESET;
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      // Reset empties the shift register and commands every output off.
      sclkPrev_q  <= 1'b0;
      selPrev_q   <= 1'b1;
      shift_q     <= SHIFT_RESET;
      cmd_q       <= CMD_ALL_OFF;
      otLatch_q   <= '0;
      ovpLatch_q  <= 1'b0;
      timer_q     <= '0;
      timerDone_q <= 1'b0;
      switchOn    <= DRIVE_RESET;
      soOut       <= 1'b0;
      soOutEn     <= 1'b0;
    end
    else
    begin
      sclkPrev_q  <= sclk;
      selPrev_q   <= selectLow;
      shift_q     <= shift_d;
      cmd_q       <= cmd_d;
      otLatch_q   <= otLatch_d;
      ovpLatch_q  <= ovpLatch_d;
      timer_q     <= timer_d;
      timerDone_q <= timerDone_d;
      switchOn    <= drive_d;
      soOut       <= so_d;
      soOutEn     <= soEn_d;
    end
  end

  property p_ovp_all_off;
    @(posedge clock) disable iff (!reset_n)
    ovpActive |=> (switchOn == 8'h00);
  endproperty
  a_ovp_all_off: assert property (p_ovp_all_off) else $error("Output on during overvoltage.");

  property p_ot_off;
    @(posedge clock) disable iff (!reset_n)
    (|overTemp) |=> ((switchOn & $past(overTemp)) == 8'h00);
  endproperty
  a_ot_off: assert property (p_ot_off) else $error("Hot output still on.");

  property p_ot_hold;
    @(posedge clock) disable iff (!reset_n)
    (|otLatch_q) |=> ((switchOn & $past(otLatch_q)) == 8'h00);
  endproperty
  a_ot_hold: assert property (p_ot_hold) else $error("Cooled output on before a write.");

  property p_status_ff;
    @(posedge clock) disable iff (!reset_n)
    (selFall && ovpActive) |=> (shift_q == 8'hFF);
  endproperty
  a_status_ff: assert property (p_status_ff) else $error("Status not all ones after overvoltage.");

  property p_cmd_load;
    @(posedge clock) disable iff (!reset_n)
    selRise |=> (cmd_q == $past(shift_q));
  endproperty
  a_cmd_load: assert property (p_cmd_load) else $error("Command not taken at select rise.");

  property p_mask;
    @(posedge clock) disable iff (!reset_n)
    selRise |=> !timerDone_q [*8];
  endproperty
  a_mask: assert property (p_mask) else $error("Fault mask ended too early.");

  property p_masked_status;
    @(posedge clock) disable iff (!reset_n)
    (selFall && !timerDone_q && !ovpActive) |=> (shift_q == $past(~switchOn));
  endproperty
  a_masked_status: assert property (p_masked_status) else $error("Status differs from drive state.");

  property p_shift;
    @(posedge clock) disable iff (!reset_n)
    (sclkRise && !selectLow && !selFall) |=> (shift_q == {$past(shift_q[6:0]), $past(si)});
  endproperty
  a_shift: assert property (p_shift) else $error("Shift register did not shift.");

  property p_so_bit;
    @(posedge clock) disable iff (!reset_n)
    (sclkRise && !selectLow && !selFall) |=> (soOut == $past(shift_q[7]));
  endproperty
  a_so_bit: assert property (p_so_bit) else $error("Serial output bit wrong.");
endmodule // osw_fault_top
`default_nettype wire

// ===== testbench/osw_host_model.sv
// Host serial master model that shifts command words out and collects status.
`timescale 1ns/1ns
`default_nettype none
module osw_host_model (
  // Serial pins
  output logic      sclk,
  output logic      selectLow,
  output logic      si,
  input  wire logic so,
  input  wire logic soEn
);
  initial
  begin
    sclk = 1'b0;
    selectLow = 1'b1;
    si = 1'b0;
  end
  // Sampling 80 ns into the 320 ns low phase leaves room for the synchroniser delay on both sides.
  task automatic xfer(input logic [7:0] cmd, output logic [7:0] rx);
    int i;
    selectLow = 1'b0;
    #320;
    for (i = 7; i >= 0; i--)
    begin
      si = cmd[i];
      #160 sclk = 1'b1;
      #160 sclk = 1'b0;
      #80 rx[i] = soEn ? so : 1'bx;
      #80;
    end
    selectLow = 1'b1;
    si = ~si;
  endtask
endmodule // osw_host_model
`default_nettype wire

// ===== testbench/osw_fault_top_tb_top.sv
// Self-checking bench of the octal switch fault status block.
`timescale 1ns/1ns
`default_nettype none
module osw_fault_top_tb_top;
  import osw_pkg::*;
  logic       clock;
  logic       reset_n;
  logic       sclkPin;
  logic       selectLowPin;
  logic       siPin;
  logic       soOut;
  logic       soOutEn;
  logic [7:0] overTempPin;
  logic       loadSupplyOverPin;
  logic [7:0] drainCompareThresholdPin;
  logic [7:0] switchOn;
  logic [7:0] expOn;
  logic [7:0] otLatch;
  logic       ovLatch;
  logic [7:0] rx;
  int         errors;
  int         compares;
  int         i;

  osw_fault_top u_osw_fault_top (
    .clock(clock), .reset_n(reset_n), .sclkPin(sclkPin), .selectLowPin(selectLowPin), .siPin(siPin),
    .soOut(soOut), .soOutEn(soOutEn), .overTempPin(overTempPin), .loadSupplyOverPin(loadSupplyOverPin),
    .drainCompareThresholdPin(drainCompareThresholdPin), .switchOn(switchOn));
  osw_host_model u_osw_host_model (
    .sclk(sclkPin), .selectLow(selectLowPin), .si(siPin), .so(soOut), .soEn(soOutEn));

  always #20 clock = ~clock;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic settle;
    repeat (12) @(negedge clock);
  endtask

  // A slow write waits over 100 us, so even the longest fault delay has expired.
  task automatic wr(input logic [7:0] cmd, input logic slow);
    logic [7:0] exp;
    if (slow)
    begin
      repeat (2600) @(negedge clock);
    end
    exp = (ovLatch | loadSupplyOverPin) ? STATUS_ALL_OFF : (slow ? drainCompareThresholdPin : ~expOn);
    u_osw_host_model.xfer(cmd, rx);
    chk(rx, exp);
    ovLatch = loadSupplyOverPin;
    otLatch = overTempPin;
    expOn = ovLatch ? 8'h00 : ~cmd & ~otLatch;
    settle();
    chk(switchOn, expOn);
    chk({7'h00, soOutEn}, 8'h00);
  endtask

  task automatic do_reset;
    reset_n = 1'b0;
    repeat (10) @(negedge clock);
    chk(switchOn, 8'h00);
    reset_n = 1'b1;
    expOn = 8'h00;
    otLatch = 8'h00;
    ovLatch = 1'b0;
    settle();
  endtask

  task automatic end_of_test;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    #3_000_000;
    errors++;
    end_of_test();
  end

  initial
  begin
    clock = 1'b0;
    reset_n = 1'b0;
    overTempPin = 8'h00;
    loadSupplyOverPin = 1'b0;
    drainCompareThresholdPin = 8'hFF;
    errors = 0;
    compares = 0;
    void'($urandom(41));
    do_reset();
    wr(8'hA5, 1'b0);
    wr(8'hA5, 1'b0);
    drainCompareThresholdPin = 8'hA5;
    wr(8'hA5, 1'b1);
    chk(rx ^ 8'hA5, 8'h00);
    $display("test startup done");
    for (i = 0; i < 12; i++)
    begin
      drainCompareThresholdPin = 8'($urandom);
      wr(8'($urandom), 1'($urandom));
    end
    $display("test random done");
    wr(8'h00, 1'b0);
    overTempPin = 8'h10;
    settle();
    expOn[4] = 1'b0;
    chk(switchOn, 8'hEF);
    wr(8'h00, 1'b0);
    overTempPin = 8'h00;
    settle();
    chk(switchOn, 8'hEF);
    wr(8'h00, 1'b0);
    $display("test overtemp done");
    loadSupplyOverPin = 1'b1;
    settle();
    expOn = 8'h00;
    chk(switchOn, expOn);
    wr(8'h00, 1'b0);
    loadSupplyOverPin = 1'b0;
    settle();
    chk(switchOn, expOn);
    ovLatch = 1'b1;
    wr(8'h3C, 1'b1);
    $display("test overvoltage done");
    do_reset();
    wr(8'h0F, 1'b0);
    $display("test reset done");
    end_of_test();
  end
endmodule // osw_fault_top_tb_top
`default_nettype wire
